// ==== rtl/pec_regs.svh ====
// Constants for the link event counter block: identifiers, size codes, reset values
`ifndef PEC_REGS_SVH
`define PEC_REGS_SVH

// Counter identifier codes, bits 11:0
`define PEC_ID_END 12'h000
`define PEC_ID_CMD_ICRC 12'h001
`define PEC_ID_DATA_RERR 12'h002
`define PEC_ID_D2H_DATA_RERR 12'h003
`define PEC_ID_H2D_DATA_RERR 12'h004
`define PEC_ID_ND_RERR 12'h005
`define PEC_ID_D2H_ND_RERR 12'h006
`define PEC_ID_H2D_ND_RERR 12'h007
`define PEC_ID_PHYRDY_ENTRY 12'h009
`define PEC_ID_SIG_FIS_OK 12'h00a
`define PEC_ID_H2D_CRC_RERR 12'h00b
`define PEC_ID_H2D_OTHER_RERR 12'h00d

// Identifier field layout
`define PEC_ID_SIZE_MSB 14
`define PEC_ID_SIZE_LSB 12
`define PEC_ID_VENDOR_BIT 15

// Size codes in identifier bits 14:12
`define PEC_SIZE_16 3'h1
`define PEC_SIZE_32 3'h2
`define PEC_SIZE_48 3'h3
`define PEC_SIZE_64 3'h4

// Reported value width and granule
`define PEC_REP_W 64
`define PEC_GRANULE 16

// Number of implemented counters; the terminator slot follows them
`define PEC_NUM_CNT 11

// Counter reset value
`define PEC_CNT_RESET 64'h0

`endif

// ==== rtl/pec_pkg.sv ====
// Types shared by the link event counter block
package pec_pkg;

    // Link-layer events, one-cycle pulses except phy_rdy which is a level
    typedef struct packed {
        logic cmd_icrc_fail;
        logic d2h_data_rerr;
        logic h2d_data_rerr;
        logic d2h_nd_rerr;
        logic h2d_nd_rerr;
        logic h2d_rerr_crc;
        logic sig_fis_rok;
        logic phy_rdy;
    } pec_evt_s;

    // One reported log entry
    typedef struct packed {
        logic [15:0] id;
        logic [63:0] value;
        logic last;
    } pec_entry_s;

    // Readout sequencer states
    typedef enum logic [0:0] {
        PEC_IDLE,
        PEC_DUMP
    } pec_state_e;

endpackage

// ==== rtl/pec_sat_counter.sv ====
// Saturating event counter with one-extended reported value
`timescale 1ns/100ps
`default_nettype none
`include "pec_regs.svh"

module pec_sat_counter #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Count control
    input wire logic [1:0] inc,
    input wire logic clr,
    // Reported value and size code
    output logic [63:0] rep_val,
    output logic [2:0] size_code
);

    localparam int RW = ((W + `PEC_GRANULE - 1) / `PEC_GRANULE) * `PEC_GRANULE;
    localparam logic [63:0] REP_MASK = {64{1'b1}} >> (`PEC_REP_W - RW);
    localparam logic [W+1:0] MAX_SUM = {2'b00, {W{1'b1}}};

    logic [W-1:0] count_r;
    logic [W+1:0] sum;

    assign sum = {2'b00, count_r} + {{W{1'b0}}, inc};

    // Count, hold at the top, and restart from any event seen on a clear
    always_ff @(posedge clock) begin
        if (srst) begin
            count_r <= '0;
        end else if (clr) begin
            count_r <= W'(inc);
        end else if (sum > MAX_SUM) begin
            count_r <= {W{1'b1}};
        end else begin
            count_r <= sum[W-1:0];
        end
    end

    // A full counter reads as ones across its whole reported width
    always_comb begin
        if (&count_r) begin
            rep_val = REP_MASK;
        end else begin
            rep_val = 64'(count_r);
        end
    end

    assign size_code = 3'(RW / `PEC_GRANULE);

endmodule
`default_nettype wire

// ==== rtl/pec_counters.sv ====
// Link event counters with log readout and clear
`timescale 1ns/100ps
`default_nettype none
`include "pec_regs.svh"

// Overview of operation
// - Identifier zero closes the reported list and carries no count.
// - Counter 1 tallies commands ending with error status and interface CRC error.
// - Counter 2 tallies data frames answered with R_ERR in either direction.
// - Counter 3 tallies outgoing data frames the host answered with R_ERR.
// - Counter 4 tallies incoming data frames answered with R_ERR; no cause split.
// - Counter 5 tallies non-data frames answered with R_ERR both ways, retries too.
// - Counter 6 tallies outgoing non-data frames answered with R_ERR, retries too.
// - Counter 7 tallies incoming non-data frames answered with R_ERR, retries too.
// - Counter 9 tallies every entry into ready link state from not-ready.
// - Power-managed link transitions may also advance counter 9.
// - Counter 10 tallies reset signature frames acknowledged with R_OK.
// - Counter 11 tallies incoming frames answered with R_ERR for CRC error.
// - Counter 13 tallies incoming frames answered with R_ERR for other causes.
// - Counters stop at maximum and report one-extended to full width.
// - Identifier bits 14:12 carry the counter size code.
// - A BIST Activate frame clears every counter; an event in the same cycle still counts.
// - A clearing log read returns current values, then clears all counters.
module pec_counters #(
    parameter int CNT_W = 32,
    parameter int PHY_CNT_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Link-layer events
    input wire pec_pkg::pec_evt_s evt,
    input wire logic ipm_enabled,
    input wire logic ipm_transition,
    // Counter clear by BIST Activate frame
    input wire logic bist_activate,
    // Log read request
    input wire logic log_start,
    input wire logic log_clear,
    // Log entry stream
    output logic log_busy,
    output logic ent_valid,
    output pec_pkg::pec_entry_s ent
);

    localparam int N = `PEC_NUM_CNT;
    localparam int SW = $clog2(N + 1);

    // Identifier table, slot order is the reporting order
    localparam logic [11:0] ID_TAB [N] = '{
        `PEC_ID_CMD_ICRC,
        `PEC_ID_DATA_RERR,
        `PEC_ID_D2H_DATA_RERR,
        `PEC_ID_H2D_DATA_RERR,
        `PEC_ID_ND_RERR,
        `PEC_ID_D2H_ND_RERR,
        `PEC_ID_H2D_ND_RERR,
        `PEC_ID_PHYRDY_ENTRY,
        `PEC_ID_SIG_FIS_OK,
        `PEC_ID_H2D_CRC_RERR,
        `PEC_ID_H2D_OTHER_RERR
    };

    // Width of each physical counter; only the link-ready counter is narrow
    localparam int W_TAB [N] = '{
        CNT_W, CNT_W, CNT_W, CNT_W, CNT_W, CNT_W, CNT_W,
        PHY_CNT_W, CNT_W, CNT_W, CNT_W
    };

    pec_pkg::pec_state_e state_r;
    logic [SW-1:0] slot_r;
    logic clear_req_r;
    logic phy_rdy_prev_r;
    logic clr_all;
    logic dump_done;
    logic phy_rise;
    logic h2d_any;
    logic [1:0] inc_vec [N];
    logic [63:0] val_vec [N];
    logic [2:0] code_vec [N];
    pec_pkg::pec_entry_s ent_nxt;
    logic ent_valid_r;
    pec_pkg::pec_entry_s ent_r;

    // Ready-state entry is a rising edge of the link ready level
    always_ff @(posedge clock) begin
        if (srst) begin
            phy_rdy_prev_r <= 1'b0;
        end else begin
            phy_rdy_prev_r <= evt.phy_rdy;
        end
    end

    // Every cause counts; power-managed entries are not filtered out
    assign phy_rise = evt.phy_rdy & ~phy_rdy_prev_r;

    // Incoming frame refused, data or non-data
    assign h2d_any = evt.h2d_data_rerr | evt.h2d_nd_rerr;

    // Increment amount per counter; combined counters may take two at once
    always_comb begin
        inc_vec[0] = {1'b0, evt.cmd_icrc_fail};
        inc_vec[1] = 2'(evt.d2h_data_rerr) + 2'(evt.h2d_data_rerr);
        inc_vec[2] = {1'b0, evt.d2h_data_rerr};
        inc_vec[3] = {1'b0, evt.h2d_data_rerr};
        inc_vec[4] = 2'(evt.d2h_nd_rerr) + 2'(evt.h2d_nd_rerr);
        inc_vec[5] = {1'b0, evt.d2h_nd_rerr};
        inc_vec[6] = {1'b0, evt.h2d_nd_rerr};
        inc_vec[7] = {1'b0, phy_rise};
        inc_vec[8] = {1'b0, evt.sig_fis_rok};
        inc_vec[9] = {1'b0, h2d_any & evt.h2d_rerr_crc};
        inc_vec[10] = {1'b0, h2d_any & ~evt.h2d_rerr_crc};
    end

    // One saturating counter per identifier
    for (genvar i = 0; i < N; i++) begin : g_cnt
        pec_sat_counter #(
            .W(W_TAB[i])
        ) u_cnt (
            .clock(clock),
            .srst(srst),
            .inc(inc_vec[i]),
            .clr(clr_all),
            .rep_val(val_vec[i]),
            .size_code(code_vec[i])
        );
    end

    // Readout reaches the terminator slot
    assign dump_done = (state_r == pec_pkg::PEC_DUMP) && (slot_r == SW'(N));

    // Clear sources: a BIST Activate frame at once, a clearing read after its last entry
    logic clr_by_bist;
    logic clr_by_read;
    assign clr_by_bist = bist_activate;
    assign clr_by_read = dump_done & clear_req_r;
    // An event in the clear cycle still counts, so the clear never loses a pulse
    assign clr_all = clr_by_bist | clr_by_read;

    // Readout sequencer: one entry per cycle, then the terminator
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= pec_pkg::PEC_IDLE;
            slot_r <= '0;
            clear_req_r <= 1'b0;
        end else begin
            case (state_r)
                pec_pkg::PEC_IDLE: begin
                    if (log_start) begin
                        state_r <= pec_pkg::PEC_DUMP;
                        slot_r <= '0;
                        clear_req_r <= log_clear;
                    end
                end
                pec_pkg::PEC_DUMP: begin
                    if (dump_done) begin
                        state_r <= pec_pkg::PEC_IDLE;
                        clear_req_r <= 1'b0;
                    end else begin
                        slot_r <= slot_r + SW'(1);
                    end
                end
                default: begin
                    state_r <= pec_pkg::PEC_IDLE;
                end
            endcase
        end
    end

    // Entry table: one row per counter, vendor bit always clear
    pec_pkg::pec_entry_s slot_ent [N+1];
    for (genvar j = 0; j < N; j++) begin : g_row
        assign slot_ent[j] = '{
            id: {1'b0, code_vec[j], ID_TAB[j]},
            value: val_vec[j],
            last: 1'b0
        };
    end

    // Terminator row closes the list and carries no count
    assign slot_ent[N] = '{
        id: {4'h0, `PEC_ID_END},
        value: `PEC_CNT_RESET,
        last: 1'b1
    };

    // Row for the current slot; any slot past the counters reads as the terminator
    always_comb begin
        ent_nxt = slot_ent[N];
        for (int k = 0; k < N; k++) begin
            if (slot_r == SW'(k)) begin
                ent_nxt = slot_ent[k];
            end
        end
    end

    // Registered entry output
    always_ff @(posedge clock) begin
        if (srst) begin
            ent_valid_r <= 1'b0;
            ent_r <= '0;
        end else begin
            ent_valid_r <= (state_r == pec_pkg::PEC_DUMP);
            if (state_r == pec_pkg::PEC_DUMP) begin
                ent_r <= ent_nxt;
            end
        end
    end

    // Outputs
    assign log_busy = (state_r == pec_pkg::PEC_DUMP);
    assign ent_valid = ent_valid_r;
    assign ent = ent_r;

    // Power management enables are informative only: all entries count,
    // so the optional filter on power-managed transitions is left out
    logic ipm_unused;
    assign ipm_unused = ipm_enabled & ipm_transition;

endmodule
`default_nettype wire

// ==== testbench/pec_counters_assertions.sv ====
// Checker for the link event counter readout stream
`timescale 1ns/100ps
`default_nettype none
module pec_counters_assertions #(
    parameter int CNT_W = 32,
    parameter int PHY_CNT_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Design inputs
    input wire pec_pkg::pec_evt_s evt,
    input wire logic ipm_enabled,
    input wire logic ipm_transition,
    input wire logic bist_activate,
    input wire logic log_start,
    input wire logic log_clear,
    // Design outputs
    input wire logic log_busy,
    input wire logic ent_valid,
    input wire pec_pkg::pec_entry_s ent
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Readout timing and list shape
    a_busy_span: assert property (log_start && !log_busy |=> log_busy [*8] ##1 log_busy [*4]
        ##1 !log_busy) else $error("busy span wrong");
    a_first_slot: assert property (log_start && !log_busy |=> !ent_valid ##1 ent_valid
        && ent.id == 16'h2001) else $error("first entry wrong");
    a_last_slot: assert property (log_start && !log_busy |-> ##13 ent_valid && ent.last)
        else $error("terminator not in slot 11");
    a_term_zero: assert property (ent_valid && ent.last |-> ent.id == 16'h0 && ent.value == 64'h0)
        else $error("terminator not zero");
    a_valid_busy: assert property (ent_valid |-> $past(log_busy)) else $error("stray entry");
    a_size_code: assert property (ent_valid && !ent.last |-> ent.id[14:12] ==
        (ent.id[11:0] == 12'h009 ? 3'h1 : 3'h2)) else $error("size code wrong");
    a_vendor_bit: assert property (ent_valid |-> !ent.id[15]) else $error("bit 15 set");
    a_phy_width: assert property (ent_valid && ent.id[11:0] == 12'h009 |->
        (ent.value >> PHY_CNT_W) == 64'h0) else $error("phy count too wide");
    a_cnt_width: assert property (ent_valid |-> (ent.value >> CNT_W) == 64'h0)
        else $error("count too wide");
    // Main scenarios reached
    c_clear_read: cover property (log_start && log_clear && !log_busy);
    c_last_entry: cover property (ent_valid && ent.last);
    c_bist: cover property (bist_activate);
endmodule
bind pec_counters pec_counters_assertions #(.CNT_W(CNT_W), .PHY_CNT_W(PHY_CNT_W)) u_chk (
    .clock(clock), .srst(srst), .evt(evt), .ipm_enabled(ipm_enabled),
    .ipm_transition(ipm_transition), .bist_activate(bist_activate), .log_start(log_start),
    .log_clear(log_clear), .log_busy(log_busy), .ent_valid(ent_valid), .ent(ent));
`default_nettype wire

// ==== testbench/pec_host_model.sv ====
// Far-side link model that produces frame outcomes and link state
`timescale 1ns/100ps
`default_nettype none
module pec_host_model (
    // Clock and traffic enable
    input wire logic clock,
    input wire logic en,
    // Link events toward the counters
    output pec_pkg::pec_evt_s evt,
    output logic ipm_enabled,
    output logic ipm_transition
);
    integer seed = 38211;
    logic [31:0] r;
    // Quiet link at time zero
    initial {evt, ipm_enabled, ipm_transition} = '0;
    // Random pulses; link level only moves while traffic runs
    always @(negedge clock) begin
        r = $random(seed);
        evt <= {en ? r[6:0] & r[13:7] : 7'h0, evt.phy_rdy ^ (en & r[16] & r[17])};
        ipm_enabled <= r[20];
        ipm_transition <= r[21];
    end
endmodule
`default_nettype wire

// ==== testbench/test_serial_link_phy_event_counters.sv ====
// Self-checking bench for the link event counters
`timescale 1ns/100ps
`default_nettype none
module test_serial_link_phy_event_counters;
    logic clock = 0, srst = 1, en = 0, bist_activate = 0, log_start = 0, log_clear = 0;
    logic log_busy, ent_valid, ipm_enabled, ipm_transition, prev_rdy = 0;
    pec_pkg::pec_evt_s evt;
    pec_pkg::pec_entry_s ent;
    integer fail_count = 0, n_checks = 0;
    longint cnt [11] = '{default: 0};
    logic [11:0] ids [11] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007,
        12'h009, 12'h00a, 12'h00b, 12'h00d};
    // Clock
    initial forever #20 clock = ~clock;
    pec_counters u_dut (.clock(clock), .srst(srst), .evt(evt), .ipm_enabled(ipm_enabled),
        .ipm_transition(ipm_transition), .bist_activate(bist_activate), .log_start(log_start),
        .log_clear(log_clear), .log_busy(log_busy), .ent_valid(ent_valid), .ent(ent));
    pec_host_model u_host (.clock(clock), .en(en), .evt(evt), .ipm_enabled(ipm_enabled),
        .ipm_transition(ipm_transition));
    // Reference tally of sampled events
    always @(posedge clock) begin
        if (!srst) begin
            cnt[0] += evt.cmd_icrc_fail;
            cnt[1] += evt.d2h_data_rerr + evt.h2d_data_rerr;
            cnt[2] += evt.d2h_data_rerr;
            cnt[3] += evt.h2d_data_rerr;
            cnt[4] += evt.d2h_nd_rerr + evt.h2d_nd_rerr;
            cnt[5] += evt.d2h_nd_rerr;
            cnt[6] += evt.h2d_nd_rerr;
            cnt[7] += evt.phy_rdy & !prev_rdy;
            cnt[8] += evt.sig_fis_rok;
            cnt[9] += evt.h2d_rerr_crc & (evt.h2d_data_rerr | evt.h2d_nd_rerr);
            cnt[10] += !evt.h2d_rerr_crc & (evt.h2d_data_rerr | evt.h2d_nd_rerr);
            prev_rdy = evt.phy_rdy;
        end
    end
    task automatic check(input logic [81:0] seen, input logic [81:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Reads the whole list; a refused start with clear is tried mid-read
    task automatic read_log(input logic clr);
        pec_pkg::pec_entry_s e;
        longint m;
        log_start = 1;
        log_clear = clr;
        @(negedge clock) log_start = 0;
        for (int k = 0; k < 12; k++) begin
            @(negedge clock);
            m = (k == 7) ? 64'hffff : 64'hffffffff;
            e.id = (k == 11) ? 16'h0 : {1'b0, (k == 7) ? 3'h1 : 3'h2, ids[k % 11]};
            e.value = (k == 11) ? 0 : (cnt[k % 11] > m ? m : cnt[k % 11]);
            e.last = (k == 11);
            check({ent_valid, ent}, {1'b1, e});
            check({81'h0, log_busy}, {81'h0, k < 11});
            if (k == 5) begin
                log_start = 1;
                log_clear = 1;
            end
            if (k == 6) log_start = 0;
        end
        if (clr) cnt = '{default: 0};
    endtask
    task automatic traffic(input int n);
        en <= 1;
        repeat (n) @(negedge clock);
        en <= 0;
        repeat (3) @(negedge clock);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence: zero after reset, traffic, plain and clearing reads, frame clear
    initial begin
        repeat (6) @(negedge clock);
        srst = 0;
        @(negedge clock);
        read_log(0);
        for (int r = 0; r < 6; r++) begin
            traffic(150);
            read_log(r[0]);
        end
        read_log(1);
        traffic(100);
        bist_activate = 1;
        @(negedge clock) bist_activate = 0;
        cnt = '{default: 0};
        @(negedge clock);
        read_log(0);
        give_verdict;
    end
    // Watchdog
    initial begin
        #200000;
        fail_count++;
        give_verdict;
    end
endmodule
`default_nettype wire
